/* design/bat_pkg.sv */
// package of constants and types for the bus address tenure block
package bat_pkg;
    localparam int ADDR_W         = 32;
    localparam int PAR_W          = 4;
    localparam int TT_W           = 5;
    localparam int SIZE_W         = 3;
    localparam int TC_W           = 2;
    localparam int CSE_W          = 1;
    localparam int DEPTH_BASE     = 1;
    localparam int DEPTH_ENH      = 2;
    localparam int MIN_IDLE_CYC   = 1;
    localparam int TT_SNOOP_BIT   = 1;
    localparam logic RST_LVL_N    = 1'b1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [TT_W-1:0]   ttype;
        logic              burst_n;
        logic [SIZE_W-1:0] tsize;
        logic [TC_W-1:0]   tcode;
        logic              ci_n;
        logic              wt_n;
        logic              gbl_n;
        logic [CSE_W-1:0]  cse;
    } bat_req_t;

    typedef enum logic [1:0] {
        BAT_IDLE,
        BAT_REQ,
        BAT_ADDR,
        BAT_GAP
    } bat_mst_t;

    // odd parity per byte, bit i covers byte i
    function automatic logic [PAR_W-1:0] bat_odd_par(input logic [ADDR_W-1:0] a);
        logic [PAR_W-1:0] p;
        p = '0;
        for (int i = 0; i < PAR_W; i++)
        begin
            p[i] = ~(^a[8*i +: 8]);
        end
        return p;
    endfunction
endpackage

/* design/bat_if.sv */
// interface joining master end and system end of the address tenure
`timescale 1ns/1ps
interface bat_if;
    import bat_pkg::*;
    logic                 bus_request_n;
    logic                 bus_grant_n;
    logic                 abb_m_o;
    logic                 abb_m_oe_n;
    logic                 abb_s_o;
    logic                 abb_s_oe_n;
    logic                 addr_bus_busy_n;
    logic                 addr_acknowledge_n;
    logic                 addr_retry_n;
    logic                 ts_m_o;
    logic                 ts_m_oe_n;
    logic                 ts_s_o;
    logic                 ts_s_oe_n;
    logic                 transfer_start_n;
    logic                 addr_m_oe_n;
    bat_req_t             attr_m;
    bat_req_t             attr_s;
    bat_req_t             attr;
    logic [PAR_W-1:0]     par_m;
    logic [PAR_W-1:0]     par_s;
    logic [PAR_W-1:0]     addr_parity;
    logic                 addr_parity_error_n;
    logic                 data_done;

    // shared wires resolved from the enables: busy and start pulled up, address and parity muxed
    assign addr_bus_busy_n  = (!abb_m_oe_n ? abb_m_o : 1'b1) & (!abb_s_oe_n ? abb_s_o : 1'b1);
    assign transfer_start_n = (!ts_m_oe_n ? ts_m_o : 1'b1) & (!ts_s_oe_n ? ts_s_o : 1'b1);
    assign attr             = !addr_m_oe_n ? attr_m : attr_s;
    assign addr_parity      = !addr_m_oe_n ? par_m : par_s;

    modport master (
        output bus_request_n, abb_m_o, abb_m_oe_n, ts_m_o, ts_m_oe_n,
        output addr_m_oe_n, attr_m, par_m, addr_parity_error_n,
        input  bus_grant_n, addr_bus_busy_n, addr_acknowledge_n, addr_retry_n,
        input  transfer_start_n, attr, addr_parity, data_done
    );
    modport system (
        output bus_grant_n, addr_acknowledge_n, addr_retry_n, data_done,
        output abb_s_o, abb_s_oe_n, ts_s_o, ts_s_oe_n, attr_s, par_s,
        input  bus_request_n, addr_bus_busy_n, transfer_start_n, attr,
        input  addr_parity_error_n
    );
endinterface

/* design/bat_master.sv */
// address tenure master end: arbitration, address transfer, parity
`timescale 1ns/1ps
module bat_master
    import bat_pkg::*;
#(
    parameter bit ENHANCED   = 1'b0,
    parameter bit APE_SUPPRESS = 1'b0
)(
    input  wire logic       clk,
    input  wire logic       rstn,
    bat_if.master           bus,
    input  wire logic       req_valid,
    input  wire bat_pkg::bat_req_t req,
    input  wire logic       req_cancel,
    output logic            req_ready,
    output logic            tenure_done,
    output logic            par_check_en,
    input  wire logic       par_check_cfg,
    input  wire logic       machine_check_enable,
    output logic            machine_check,
    output logic            checkstop
);
    import bat_pkg::*;

    localparam int MAX_OUT = ENHANCED ? DEPTH_ENH : DEPTH_BASE;

    bat_mst_t     st_ff, nxt_st;
    bat_req_t     hold_ff, nxt_hold;
    logic         br_ff, nxt_br;
    logic         abb_ff, nxt_abb;
    logic         ts_ff, nxt_ts;
    logic         drv_ff, nxt_drv;
    logic [1:0]   outst_ff, nxt_outst;
    logic         mc_ff, nxt_mc;
    logic         cs_ff, nxt_cs;
    logic         ape_ff, nxt_ape;
    logic         qual_gnt;
    logic         room;
    logic         snoop_hit;
    logic [PAR_W-1:0] par_calc;

    assign qual_gnt  = !bus.bus_grant_n && bus.addr_bus_busy_n && bus.addr_retry_n;
    assign room      = (outst_ff < 2'(MAX_OUT + 1));
    assign req_ready = (st_ff == BAT_IDLE || st_ff == BAT_REQ) && qual_gnt && room;
    assign par_calc  = bat_odd_par(bus.attr.addr);
    // late start from others sampled alone
    assign snoop_hit = drv_ff == 1'b0 && !bus.transfer_start_n && !bus.attr.gbl_n
                       && bus.attr.ttype[TT_SNOOP_BIT];

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_hold  = hold_ff;
        nxt_br    = 1'b1;
        nxt_abb   = abb_ff;
        nxt_ts    = 1'b1;
        nxt_drv   = drv_ff;
        nxt_outst = outst_ff;
        nxt_mc    = mc_ff;
        nxt_cs    = cs_ff;
        nxt_ape   = 1'b1;
        tenure_done = 1'b0;
        if (bus.data_done && outst_ff != 2'h0)
        begin
            nxt_outst = outst_ff - 2'h1;
        end
        case (st_ff)
            BAT_IDLE, BAT_REQ:
            begin
                if (req_valid && !req_cancel && room && qual_gnt)
                begin
                    // assert busy and start, drive address
                    nxt_hold = req;
                    nxt_abb  = 1'b0;
                    nxt_ts   = 1'b0;
                    nxt_drv  = 1'b1;
                    nxt_st   = BAT_ADDR;
                end
                else if (req_valid && !req_cancel)
                begin
                    nxt_br = 1'b0;
                    nxt_st = BAT_REQ;
                end
                else
                begin
                    nxt_st = BAT_IDLE;
                end
            end
            BAT_ADDR:
            begin
                if (!bus.addr_acknowledge_n && ts_ff)
                begin
                    nxt_abb = 1'b1;
                    nxt_drv = 1'b0;
                    nxt_st  = BAT_GAP;
                    tenure_done = bus.addr_retry_n;
                    if (bus.addr_retry_n)
                    begin
                        nxt_outst = nxt_outst + 2'h1;
                    end
                end
            end
            BAT_GAP:
            begin
                nxt_st = BAT_IDLE;
                nxt_br = !(req_valid && !req_cancel);
            end
            default:
            begin
                nxt_st = BAT_IDLE;
            end
        endcase
        // compare only on snooped global starts
        if (snoop_hit && (par_calc != bus.addr_parity))
        begin
            nxt_ape = APE_SUPPRESS && !par_check_cfg;
            // machine check or checkstop when enabled
            if (par_check_cfg)
            begin
                if (machine_check_enable)
                begin
                    nxt_mc = 1'b1;
                end
                else
                begin
                    nxt_cs = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_ff    <= BAT_IDLE;
            hold_ff  <= '0;
            br_ff    <= RST_LVL_N;
            abb_ff   <= RST_LVL_N;
            ts_ff    <= RST_LVL_N;
            drv_ff   <= 1'b0;
            outst_ff <= 2'h0;
            mc_ff    <= 1'b0;
            cs_ff    <= 1'b0;
            ape_ff   <= RST_LVL_N;
        end
        else
        begin
            st_ff    <= nxt_st;
            hold_ff  <= nxt_hold;
            br_ff    <= nxt_br;
            abb_ff   <= nxt_abb;
            ts_ff    <= nxt_ts;
            drv_ff   <= nxt_drv;
            outst_ff <= nxt_outst;
            mc_ff    <= nxt_mc;
            cs_ff    <= nxt_cs;
            ape_ff   <= nxt_ape;
        end
    end

    assign bus.abb_m_o      = abb_ff;
    assign bus.abb_m_oe_n   = !drv_ff && abb_ff;
    assign bus.bus_request_n = br_ff;
    assign bus.ts_m_o       = ts_ff;
    assign bus.ts_m_oe_n    = !drv_ff;
    assign bus.attr_m       = hold_ff;
    assign bus.addr_m_oe_n  = !drv_ff;
    assign bus.par_m        = bat_odd_par(hold_ff.addr);
    assign bus.addr_parity_error_n = ape_ff;
    assign par_check_en     = par_check_cfg;
    assign machine_check    = mc_ff;
    assign checkstop        = cs_ff;
endmodule

/* design/bat_system.sv */
// system end: central arbiter, address acknowledge and data completion
`timescale 1ns/1ps
module bat_system
    import bat_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    bat_if.system           bus,
    input  wire logic       park_en,
    input  wire logic       single_master,
    input  wire logic       retry_req,
    input  wire logic [1:0] addr_acknowledge_n_delay,
    input  wire logic       data_done_in,
    output logic            ape_seen
);
    import bat_pkg::*;

    logic       gnt_ff, nxt_gnt;
    logic       addr_acknowledge_n_ff, nxt_addr_acknowledge_n;
    logic       pend_ff, nxt_pend;
    logic [1:0] cnt_ff, nxt_cnt;
    logic       ape_ff, nxt_ape;

    always_comb
    begin
        nxt_gnt  = gnt_ff;
        nxt_addr_acknowledge_n = 1'b1;
        nxt_pend = pend_ff;
        nxt_cnt  = cnt_ff;
        nxt_ape  = !bus.addr_parity_error_n;
        if (single_master || park_en)
        begin
            nxt_gnt = 1'b0;
        end
        else
        begin
            nxt_gnt = bus.bus_request_n;
        end
        if (!bus.transfer_start_n)
        begin
            nxt_pend = 1'b1;
            nxt_cnt  = addr_acknowledge_n_delay;
        end
        else if (pend_ff && cnt_ff != 2'h0)
        begin
            nxt_cnt = cnt_ff - 2'h1;
        end
        else if (pend_ff)
        begin
            nxt_addr_acknowledge_n = 1'b0;
            nxt_pend = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            gnt_ff  <= RST_LVL_N;
            addr_acknowledge_n_ff <= RST_LVL_N;
            pend_ff <= 1'b0;
            cnt_ff  <= 2'h0;
            ape_ff  <= 1'b0;
        end
        else
        begin
            gnt_ff  <= nxt_gnt;
            addr_acknowledge_n_ff <= nxt_addr_acknowledge_n;
            pend_ff <= nxt_pend;
            cnt_ff  <= nxt_cnt;
            ape_ff  <= nxt_ape;
        end
    end

    assign bus.bus_grant_n        = gnt_ff;
    assign bus.addr_acknowledge_n = addr_acknowledge_n_ff;
    assign bus.addr_retry_n       = !(retry_req && !addr_acknowledge_n_ff);
    assign bus.data_done          = data_done_in;
    assign bus.abb_s_o            = 1'b1;
    assign bus.abb_s_oe_n         = 1'b1;
    assign bus.ts_s_o             = 1'b1;
    assign bus.ts_s_oe_n          = 1'b1;
    assign bus.attr_s             = '0;
    assign bus.par_s              = '0;
    assign ape_seen               = ape_ff;
endmodule

/* verif/bat_checker.sv */
// concurrent checks on the address tenure interface
`timescale 1ns/1ps
module bat_checker (
    input wire logic                      clk,
    input wire logic                      rstn,
    input wire logic                      bus_request_n,
    input wire logic                      bus_grant_n,
    input wire logic                      addr_bus_busy_n,
    input wire logic                      addr_acknowledge_n,
    input wire logic                      addr_retry_n,
    input wire logic                      transfer_start_n,
    input wire logic                      ts_m_o,
    input wire logic                      ts_m_oe_n,
    input wire logic                      addr_m_oe_n,
    input wire bat_pkg::bat_req_t         attr,
    input wire logic [bat_pkg::PAR_W-1:0] addr_parity
);
    import bat_pkg::*;
    logic             m_ts;
    logic             qual;
    logic             hold;
    logic [PAR_W-1:0] exp_par;
    assign m_ts = !ts_m_oe_n && !ts_m_o;
    assign qual = !bus_grant_n && addr_bus_busy_n && addr_retry_n;
    assign hold = !addr_m_oe_n && !addr_bus_busy_n && transfer_start_n;
    assign exp_par = {~^attr.addr[31:24], ~^attr.addr[23:16], ~^attr.addr[15:8], ~^attr.addr[7:0]};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ts_pulse_a: assert property (m_ts |=> !m_ts)
        else $error("start longer than one cycle");
    start_busy_a: assert property (m_ts |-> !addr_bus_busy_n && bus_request_n)
        else $error("start without busy or with request");
    qual_grant_a: assert property (m_ts |-> $past(qual))
        else $error("start without qualified grant");
    ack_late_a: assert property (!transfer_start_n |-> addr_acknowledge_n)
        else $error("acknowledge with start");
    ack_bound_a: assert property (m_ts |-> ##[2:5] !addr_acknowledge_n)
        else $error("acknowledge missing");
    ack_pulse_a: assert property (!addr_acknowledge_n |=> addr_acknowledge_n)
        else $error("acknowledge longer than one cycle");
    busy_release_a: assert property (
        !addr_acknowledge_n && !addr_bus_busy_n |=> addr_bus_busy_n && transfer_start_n)
        else $error("busy not released after acknowledge");
    attr_hold_a: assert property (hold |-> $stable(attr))
        else $error("attributes changed in tenure");
    par_gen_a: assert property (hold |-> addr_parity == exp_par)
        else $error("wrong address parity");
    start_c: cover property (m_ts);
    slow_ack_c: cover property (m_ts ##5 !addr_acknowledge_n);
    back_to_back_c: cover property (!addr_acknowledge_n ##3 m_ts);
endmodule

/* verif/bus_address_tenure_tb.sv */
// self-checking bench joining master and system ends of the address tenure
`timescale 1ns/1ps
module bus_address_tenure_tb;
    import bat_pkg::*;
    logic       clk, rstn, rst2_n, req_valid, req_cancel, par_check_cfg, mce;
    logic       park_en, single_master, data_done_in, req_ready, tenure_done;
    logic       ape_seen, mc2, cs2, pce2, retry_req;
    logic [1:0] addr_acknowledge_n_delay;
    bit         t;
    bat_req_t   req, a, b, m_exp;
    bat_req_t   q_attr[$];
    int         errors, n_tests, n_done, n_sent, seed, i, k;
    logic [3:0] cases[5] = '{4'hF, 4'hB, 4'h3, 4'hE, 4'hD};
    bat_if if1();
    bat_if if2();
    bat_master bat_master_inst (.clk(clk), .rstn(rstn), .bus(if1), .req_valid(req_valid),
        .req(req), .req_cancel(req_cancel), .req_ready(req_ready), .tenure_done(tenure_done),
        .par_check_en(), .par_check_cfg(par_check_cfg), .machine_check_enable(mce),
        .machine_check(), .checkstop());
    bat_master bat_master_snoop_inst (.clk(clk), .rstn(rst2_n), .bus(if2), .req_valid(1'b0),
        .req('0), .req_cancel(1'b0), .req_ready(), .tenure_done(), .par_check_en(pce2),
        .par_check_cfg(par_check_cfg), .machine_check_enable(mce), .machine_check(mc2),
        .checkstop(cs2));
    bat_system bat_system_inst (.clk(clk), .rstn(rstn), .bus(if1), .park_en(park_en),
        .single_master(single_master), .retry_req(retry_req), .addr_acknowledge_n_delay(addr_acknowledge_n_delay),
        .data_done_in(data_done_in), .ape_seen(ape_seen));
    bat_checker bat_checker_inst (.clk(clk), .rstn(rstn), .bus_request_n(if1.bus_request_n),
        .bus_grant_n(if1.bus_grant_n), .addr_bus_busy_n(if1.addr_bus_busy_n),
        .addr_acknowledge_n(if1.addr_acknowledge_n), .addr_retry_n(if1.addr_retry_n),
        .transfer_start_n(if1.transfer_start_n), .ts_m_o(if1.ts_m_o),
        .ts_m_oe_n(if1.ts_m_oe_n), .addr_m_oe_n(if1.addr_m_oe_n), .attr(if1.attr),
        .addr_parity(if1.addr_parity));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [3:0] opar(input logic [31:0] x);
        return {~^x[31:24], ~^x[23:16], ~^x[15:8], ~^x[7:0]};
    endfunction

    function automatic bat_req_t rnd();
        logic [63:0] w;
        w = {$random(seed), $random(seed)};
        return w[$bits(bat_req_t)-1:0];
    endfunction

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic send(input bat_req_t s, input int lim, output bit took);
        int n;
        n = 0;
        req = s;
        req_valid = 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        took = (req_ready === 1'b1);
        if (took)
            q_attr.push_back(s);
        step();
    endtask

    task automatic wait_done(input int target);
        int n;
        n = 0;
        while (n_done < target && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        if (n_done < target)
        begin
            cmp("tenure completion", 64'h1, 64'h0);
            stop_test();
        end
        step();
    endtask

    task automatic pulse_done();
        data_done_in = 1'b1;
        step();
        data_done_in = 1'b0;
        step();
    endtask

    // snooped transfer from another master: late start, chosen parity
    task automatic snoop(input logic [3:0] c);
        bat_req_t s;
        s = rnd();
        s.gbl_n = !c[1];
        s.ttype[TT_SNOOP_BIT] = 1'b1;
        step();
        par_check_cfg = c[3];
        mce = c[2];
        rst2_n = 1'b0;
        step();
        rst2_n = 1'b1;
        if2.abb_s_oe_n = 1'b0;
        if2.abb_s_o = 1'b0;
        step();
        if2.attr_s = s;
        if2.par_s = opar(s.addr) ^ {3'h0, c[0]};
        if2.ts_s_oe_n = 1'b0;
        if2.ts_s_o = 1'b0;
        step();
        if2.ts_s_oe_n = 1'b1;
        if2.attr_s = ~s;
        if2.par_s = ~if2.par_s;
        @(negedge clk);
        cmp("parity error line", 64'(!(c[1] && c[0])), 64'(if2.addr_parity_error_n));
        repeat (2) @(negedge clk);
        cmp("machine check", 64'(c == 4'hF), 64'(mc2));
        cmp("checkstop", 64'(c == 4'hB), 64'(cs2));
        cmp("check enable", 64'(c[3]), 64'(pce2));
        step();
        if2.abb_s_oe_n = 1'b1;
    endtask

    always @(negedge clk)
    begin
        if (rstn === 1'b1 && tenure_done === 1'b1)
            n_done++;
        if (rstn === 1'b1 && if1.transfer_start_n === 1'b0)
        begin
            if (q_attr.size() == 0)
                cmp("unexpected start", 64'h0, 64'h1);
            else
            begin
                m_exp = q_attr.pop_front();
                cmp("attributes", 64'(m_exp), 64'(if1.attr));
                cmp("address parity", 64'(opar(m_exp.addr)), 64'(if1.addr_parity));
            end
        end
    end

    initial
    begin
        seed = 32'h27e2400d;
        {rstn, rst2_n, req_valid, req_cancel, par_check_cfg, mce} = '0;
        {park_en, single_master, data_done_in, addr_acknowledge_n_delay, req, retry_req} = '0;
        {if2.bus_grant_n, if2.addr_acknowledge_n, if2.addr_retry_n} = 3'h7;
        {if2.abb_s_o, if2.abb_s_oe_n, if2.ts_s_o, if2.ts_s_oe_n} = 4'hF;
        if2.data_done = 1'b0;
        if2.attr_s = '0;
        if2.par_s = '0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (k = 0; k < 3; k++)
        begin
            park_en = (k == 1);
            single_master = (k == 2);
            for (i = 0; i < 4; i++)
            begin
                addr_acknowledge_n_delay = (i == 3) ? 2'h3 : 2'($random(seed));
                a = rnd();
                b = rnd();
                if (i == 0)
                    {a.addr, b.addr} = {32'h0000_0000, 32'hFFFF_FFFF};
                send(a, 40, t);
                send(b, 40, t);
                req_valid = 1'b0;
                n_sent += 2;
                wait_done(n_sent);
                pulse_done();
                pulse_done();
            end
        end
        send(a, 40, t);
        send(b, 40, t);
        n_sent += 2;
        wait_done(n_sent);
        send(a, 20, t);
        cmp("third tenure refused", 64'h0, 64'(t));
        cmp("request held", 64'h0, 64'(if1.bus_request_n));
        req_valid = 1'b0;
        pulse_done();
        send(a, 40, t);
        req_valid = 1'b0;
        n_sent += 1;
        wait_done(n_sent);
        pulse_done();
        pulse_done();
        single_master = 1'b0;
        step();
        req_valid = 1'b1;
        step();
        step();
        cmp("request raised", 64'h0, 64'(if1.bus_request_n));
        req_cancel = 1'b1;
        repeat (10) step();
        cmp("cancelled request", 64'h1, 64'(if1.bus_request_n));
        req_valid = 1'b0;
        req_cancel = 1'b0;
        retry_req = 1'b1;
        send(a, 40, t);
        req_valid = 1'b0;
        repeat (12) step();
        cmp("retried tenure", 64'(n_sent), 64'(n_done));
        retry_req = 1'b0;
        for (i = 0; i < 5; i++)
            snoop(cases[i]);
        cmp("error seen by system", 64'h0, 64'(ape_seen));
        cmp("pending tenures", 64'h0, 64'(q_attr.size()));
        stop_test();
    end
endmodule
